// ---- verilog/ilc_map.vh ----
// register map, address and timing constants for the led current target
`ifndef ILC_MAP_VH
`define ILC_MAP_VH
`define ILC_TARGET_ADDR 7'h4f
`define ILC_REG_LED_CONTROL 8'h01
`define ILC_LED_CONTROL_RESET 8'h00
`define ILC_BIT_INDICATOR 5
`define ILC_CODE_MSB 4
`define ILC_CODE_MAX 5'h1e
`define ILC_STEP_REF_MULT 16
`define ILC_INDICATOR_UA 450
`define ILC_SYNC_CYCLES 2
`endif

// ---- verilog/ilc_edge_sampler.v ----
// registers scl and sda and reports edges, start and stop events
module ilc_edge_sampler (
  input wire core_clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg scl_q,
  output reg sda_q,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det
);
  reg scl_prev_q;
  reg sda_prev_q;

  // inputs are synchronous to core_clk, so one stage is enough for edges
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_prev_q;
  assign scl_fall = ~scl_q & scl_prev_q;
  // sda moving while scl stays high marks frame boundaries
  assign start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  assign stop_det = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
endmodule // ilc_edge_sampler

// ---- verilog/ilc_led_target.v ----
// write-only i2c target holding the led control register
`include "ilc_map.vh"

module ilc_led_target (
  input wire core_clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg converter_en,
  output reg primary_led_sink_en,
  output reg secondary_led_sink_en,
  output reg indicator_mode,
  output reg [4:0] primary_current_code,
  output reg [4:0] secondary_current_code,
  output reg [7:0] led_control_register
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RECV = 5'h02;
  localparam [4:0] ST_ACK = 5'h04;
  localparam [4:0] ST_ACK_END = 5'h08;
  localparam [4:0] ST_IGNORE = 5'h10;
  localparam [2:0] MODE_OFF = 3'h1;
  localparam [2:0] MODE_IND = 3'h2;
  localparam [2:0] MODE_NORM = 3'h4;

  wire sda_q;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  reg [4:0] state_q;
  reg [7:0] shift_q;
  reg [2:0] bit_cnt_q;
  reg [1:0] byte_idx_q;
  reg [7:0] index_q;
  reg [7:0] ctrl_q;
  wire [7:0] byte_now;
  reg [2:0] mode_d;
  reg converter_en_d;
  reg primary_en_d;
  reg secondary_en_d;
  reg [4:0] code_d;

  ilc_edge_sampler u_sampler (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_q(),
    .sda_q(sda_q),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  assign byte_now = {shift_q[6:0], sda_q};

  function addr_match;
    input [7:0] b;
    begin
      addr_match = (b[7:1] == `ILC_TARGET_ADDR) && !b[0];
    end
  endfunction

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      byte_idx_q <= 2'h0;
      index_q <= 8'h00;
      ctrl_q <= `ILC_LED_CONTROL_RESET;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      // repeated start restarts the byte count
      state_q <= ST_RECV;
      bit_cnt_q <= 3'h0;
      byte_idx_q <= 2'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_RECV: begin
          if (scl_rise) begin
            shift_q <= byte_now;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              state_q <= ST_ACK;
              if (byte_idx_q == 2'h0) begin
                // wrong address or read: stay off the bus until the next start or stop
                if (!addr_match(byte_now))
                  state_q <= ST_IGNORE;
              end else if (byte_idx_q == 2'h1) begin
                index_q <= byte_now;
              end else if (index_q == `ILC_REG_LED_CONTROL) begin
                // latched on the eighth rising scl, before the ack
                ctrl_q <= byte_now;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b1;
            state_q <= ST_ACK_END;
          end
        end
        ST_ACK_END: begin
          if (scl_fall) begin
            // release after the ninth clock; never drive data back
            sda_oe <= 1'b0;
            sda_out <= 1'b1;
            if (byte_idx_q != 2'h3)
              byte_idx_q <= byte_idx_q + 2'h1;
            state_q <= ST_RECV;
          end
        end
        ST_IGNORE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // operating mode of the sinks: off, indicator or normal, one-hot
  function [2:0] mode_of;
    input [7:0] r;
    begin
      if (r == 8'h00)
        mode_of = MODE_OFF;
      else if (r[`ILC_BIT_INDICATOR])
        mode_of = MODE_IND;
      else
        mode_of = MODE_NORM;
    end
  endfunction

  // code handed to the sinks; codes above thirty pass through unclipped
  function [4:0] code_of;
    input [7:0] r;
    begin
      if (mode_of(r) == MODE_NORM)
        code_of = r[`ILC_CODE_MSB:0];
      else
        code_of = 5'h00;
    end
  endfunction

  // decode kept apart from the flops so each port is a plain register
  always @* begin
    mode_d = mode_of(ctrl_q);
    converter_en_d = 1'b0;
    primary_en_d = 1'b0;
    secondary_en_d = 1'b0;
    code_d = code_of(ctrl_q);
    case (mode_d)
      MODE_OFF: begin
        // converter and both sinks dropped
        secondary_en_d = 1'b0;
      end
      MODE_IND: begin
        // fixed indicator current in the analog sink, converter off
        secondary_en_d = 1'b1;
      end
      MODE_NORM: begin
        // each code lsb is one step of sixteen reference currents
        converter_en_d = 1'b1;
        primary_en_d = 1'b1;
        secondary_en_d = 1'b1;
      end
      default: begin
        converter_en_d = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_control_register <= `ILC_LED_CONTROL_RESET;
      converter_en <= 1'b0;
      primary_led_sink_en <= 1'b0;
      secondary_led_sink_en <= 1'b0;
      indicator_mode <= 1'b0;
      primary_current_code <= 5'h00;
      secondary_current_code <= 5'h00;
    end else begin
      led_control_register <= ctrl_q; // reserved bits stored too; they count in the zero test for off mode
      indicator_mode <= ctrl_q[`ILC_BIT_INDICATOR];
      converter_en <= converter_en_d;
      primary_led_sink_en <= primary_en_d;
      secondary_led_sink_en <= secondary_en_d;
      primary_current_code <= code_d;
      secondary_current_code <= code_d;
    end
  end
endmodule // ilc_led_target

// ---- verification/ilc_led_checker.sv ----
// concurrent checks on the led target ports
module ilc_led_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic converter_en,
  input wire logic primary_led_sink_en,
  input wire logic secondary_led_sink_en,
  input wire logic indicator_mode,
  input wire logic [4:0] primary_current_code,
  input wire logic [4:0] secondary_current_code,
  input wire logic [7:0] led_control_register
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // an ack covers the whole ninth scl period, at least 8 cycles
  sequence s_ack;
    sda_oe [*8];
  endsequence
  a_ack_low: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_ack_hold: assert property ($rose(sda_oe) |-> s_ack)
    else $error("ack cut short");
  a_load_early: assert property ($changed(led_control_register) |->
    !sda_oe) else $error("register loaded during ack");
  a_zero_off: assert property (led_control_register == 8'h00 |->
    !(converter_en | primary_led_sink_en | secondary_led_sink_en))
    else $error("outputs on with zero register");
  a_ind_off: assert property (indicator_mode |->
    !converter_en && !primary_led_sink_en) else $error("indicator drive");
  a_ind_fixed: assert property (indicator_mode |->
    secondary_led_sink_en && secondary_current_code == 5'h00)
    else $error("indicator sink wrong");
  a_mode_bit: assert property (indicator_mode ==
    led_control_register[5]) else $error("mode bit mismatch");
  a_norm_code: assert property (!indicator_mode &&
    led_control_register != 8'h00 |-> converter_en && secondary_led_sink_en
    && primary_current_code == led_control_register[4:0]
    && secondary_current_code == primary_current_code)
    else $error("normal code wrong");
endmodule // ilc_led_checker

bind ilc_led_target ilc_led_checker ilc_led_checker_inst (.*);

// ---- verification/ilc_host_model.sv ----
// i2c host model sending write frames to the led target
module ilc_host_model (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // data changes only while scl is low, 5 cycles per phase
  task automatic bit9(input logic b, output logic r);
    sda_low = !b;
    wt(4);
    scl = 1'b1;
    wt(3);
    r = sda;
    wt(2);
    scl = 1'b0;
    wt(1);
  endtask
  // start, three bytes msb first each with an ack slot, stop
  task automatic frame(input logic [23:0] f, output logic [2:0] ack);
    logic r;
    sda_low = 1'b1;
    wt(5);
    scl = 1'b0;
    wt(1);
    for (int k = 23; k >= 0; k--) begin
      bit9(f[k], r);
      if (k % 8 == 0) begin
        bit9(1'b1, r);
        ack[k / 8] = !r;
      end
    end
    sda_low = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b0;
    wt(8);
  endtask
endmodule // ilc_host_model

// ---- verification/i2c_led_current_control_tb_top.sv ----
// testbench for the led current target
module i2c_led_current_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, sda_low, sda, sda_out, sda_oe, conv, pen, sen, ind;
  logic [4:0] pc, sc;
  logic [7:0] lr;
  logic [2:0] ack;
  int failures = 0;
  int checked = 0;
  always #20 core_clk = ~core_clk;
  // pull-up: the wire is low only while someone pulls it low
  assign sda = !(sda_low || (sda_oe && !sda_out));
  ilc_led_target ilc_led_target_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .converter_en(conv), .primary_led_sink_en(pen),
    .secondary_led_sink_en(sen), .indicator_mode(ind),
    .primary_current_code(pc), .secondary_current_code(sc),
    .led_control_register(lr));
  ilc_host_model ilc_host_model_inst (.core_clk(core_clk), .sda(sda),
    .scl(scl), .sda_low(sda_low));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, i, v, input logic [2:0] e);
    ilc_host_model_inst.frame({a, i, v}, ack);
    chk(ack, e);
  endtask
  task automatic outs(input logic [7:0] v);
    chk(lr, v);
    chk({conv, pen, sen, ind},
      {v != 0 && !v[5], v != 0 && !v[5], v != 0, v[5]});
    chk({pc, sc}, (v == 0 || v[5]) ? 10'h0 : {2{v[4:0]}});
  endtask
  task automatic t_normal;
    for (int b = 0; b < 5; b++) begin
      wr(8'h9e, 8'h01, 8'h01 << b, 3'h7);
      outs(8'h01 << b);
    end
    wr(8'h9e, 8'h01, 8'h1e, 3'h7);
    outs(8'h1e);
  endtask
  task automatic t_indicator;
    wr(8'h9e, 8'h01, 8'h3f, 3'h7);
    outs(8'h3f);
    wr(8'h9e, 8'h01, 8'hc5, 3'h7);
    outs(8'hc5);
  endtask
  task automatic t_refused;
    wr(8'h9c, 8'h01, 8'h0a, 3'h0);
    wr(8'h9f, 8'h01, 8'h0a, 3'h0);
    wr(8'h9e, 8'h02, 8'h0a, 3'h7);
    outs(8'hc5);
    wr(8'h9e, 8'h01, 8'h00, 3'h7);
    outs(8'h00);
  endtask
  task automatic close_out;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2ms;
    failures++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    outs(8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    t_normal();
    t_indicator();
    t_refused();
    close_out();
  end
endmodule // i2c_led_current_control_tb_top
